//--- hdl/sccfg_pkg.sv
// constants and types for the system clock configuration block
package sccfg_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] LOOP_CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] CLOCK_CFG_OFFSET = 8'h04;
    localparam logic [31:0] CLOCK_CFG_RESET = 32'h2000_0000;
    localparam logic [31:0] CLOCK_CFG_WMASK = 32'hFFBF_3FF3;
    localparam int OUT_DIV_LSB = 28;
    localparam int MUL_HI_BIT = 27;
    localparam int OUT_SEL_LSB = 23;
    localparam int MUL_LO_LSB = 18;
    localparam int HALVER_BIT = 17;
    localparam int LOOP_SRC_BIT = 16;
    localparam int FAST_DIV_LSB = 11;
    localparam int SLOW_DIV_LSB = 8;
    localparam int MAIN_DIV_LSB = 4;
    localparam int STATUS_LSB = 2;
    localparam int SELECT_LSB = 0;
    localparam int CTL_LOOP_EN_BIT = 24;
    localparam int CTL_LOOP_RDY_BIT = 25;
    localparam int CTL_FAIL_EN_BIT = 19;
    localparam int CTL_EXT_RDY_BIT = 17;
    localparam int CTL_INT_RDY_BIT = 1;
    localparam logic [1:0] SRC_INT_FAST = 2'h0;
    localparam logic [1:0] SRC_EXT_FAST = 2'h1;
    localparam logic [1:0] SRC_LOOP = 2'h2;
    localparam logic [1:0] SRC_FORBIDDEN = 2'h3;
    localparam logic [4:0] MUL_DOUBLE_CODE = 5'h0F;
    localparam logic [3:0] OUT_SEL_LAST = 4'hD;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        SW_STABLE = 2'b01,
        SW_WAIT = 2'b10
    } sccfg_sw_e;
endpackage

//--- hdl/sccfg_sync2.sv
// two flip-flop synchroniser for asynchronous level inputs
module sccfg_sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- hdl/sccfg_shift_decode.sv
// turns a bus divider code into a registered power-of-two shift
module sccfg_shift_decode #(
    parameter int W = 3
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [W-1:0] code,
    output logic [W-1:0] shift_q
);
    logic [W-1:0] low;
    logic [W-1:0] shift_d;
    always_comb
    begin
        low = {1'b0, code[W-2:0]};
        shift_d = '0;
        if (code[W-1])
        begin
            shift_d = W'(low + W'(1));
            if (low >= W'(4))
            begin
                // codes 1100..1111 skip divide by 32
                shift_d = W'(low + W'(2));
            end
        end
    end
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            shift_q <= '0;
        else
            shift_q <= shift_d;
    end
endmodule

//--- hdl/sccfg_top.sv
// clock configuration register with source switching and axi4-lite access
module sccfg_top
    import sccfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic internal_fast_ready,
    input wire logic external_fast_ready,
    input wire logic loop_ready,
    input wire logic external_fast_fail,
    input wire logic lowpower_enter,
    input wire logic lowpower_exit,
    output logic [1:0] system_clock_mux_sel,
    output logic loop_enable,
    output logic [5:0] loop_multiplier,
    output logic loop_input_halver,
    output logic loop_source_select,
    output logic [3:0] main_bus_shift,
    output logic [2:0] fast_periph_bus_shift,
    output logic [2:0] slow_periph_bus_shift,
    output logic clock_output_enable,
    output logic [2:0] clock_output_select,
    output logic [3:0] output_clock_divider,
    output logic fail_detect_armed
);
    logic irdy_s;
    logic xrdy_s;
    logic lrdy_s;
    logic fail_s;
    sccfg_sync2 #(.W(4)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({internal_fast_ready, external_fast_ready, loop_ready,
                   external_fast_fail}),
        .sync_out({irdy_s, xrdy_s, lrdy_s, fail_s})
    );

    // write channel
    logic aw_hold_q, aw_hold_d;
    logic w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wr_mask;
    logic aw_have;
    logic w_have;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_comb
    begin
        aw_have = aw_hold_q || (s_axi_awvalid && s_axi_awready);
        w_have = w_hold_q || (s_axi_wvalid && s_axi_wready);
        wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
        wr_data = w_hold_q ? w_data_q : s_axi_wdata;
        wr_mask = '0;
        for (int i = 0; i < 4; i++)
        begin
            wr_mask[8*i +: 8] = {8{w_hold_q ? w_strb_q[i] : s_axi_wstrb[i]}};
        end
        wr_en = aw_have && w_have;
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_en)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_addr == CLOCK_CFG_OFFSET ||
                       wr_addr == LOOP_CTRL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // configuration and control registers
    logic [31:0] cfg_q, cfg_d;
    logic len_q, len_d;
    logic cfd_q, cfd_d;
    logic armed_q, armed_d;
    logic [1:0] mux_q, mux_d;
    sccfg_sw_e sw_q, sw_d;
    logic [31:0] merged;
    logic [31:0] ctl_read;
    logic fail_event;
    logic tgt_rdy;
    logic [1:0] req_sel;

    assign fail_event = armed_q && fail_s;
    assign req_sel = cfg_q[SELECT_LSB +: 2];

    always_comb
    begin
        cfg_d = cfg_q;
        len_d = len_q;
        cfd_d = cfd_q;
        merged = (cfg_q & ~wr_mask) | (wr_data & wr_mask);
        if (wr_en && wr_addr == CLOCK_CFG_OFFSET)
        begin
            cfg_d = (cfg_q & ~CLOCK_CFG_WMASK) | (merged & CLOCK_CFG_WMASK);
            if (len_q)
            begin
                cfg_d[MUL_HI_BIT] = cfg_q[MUL_HI_BIT];
                cfg_d[MUL_LO_LSB +: 4] = cfg_q[MUL_LO_LSB +: 4];
                cfg_d[HALVER_BIT] = cfg_q[HALVER_BIT];
                cfg_d[LOOP_SRC_BIT] = cfg_q[LOOP_SRC_BIT];
            end
            if (merged[SELECT_LSB +: 2] == SRC_FORBIDDEN)
                cfg_d[SELECT_LSB +: 2] = cfg_q[SELECT_LSB +: 2];
        end
        if (wr_en && wr_addr == LOOP_CTRL_OFFSET)
        begin
            cfd_d = merged[CTL_FAIL_EN_BIT];
            if (merged[CTL_LOOP_EN_BIT] || mux_q != SRC_LOOP)
                len_d = merged[CTL_LOOP_EN_BIT];
        end
        if (lowpower_enter)
            len_d = 1'b0;
        if (lowpower_exit || fail_event)
            cfg_d[SELECT_LSB +: 2] = SRC_INT_FAST;
        cfg_d[STATUS_LSB +: 2] = 2'h0;
        armed_d = cfd_q && (armed_q || xrdy_s);
    end

    // source switch waits for the requested clock to be ready
    always_comb
    begin
        case (req_sel)
            SRC_INT_FAST: tgt_rdy = irdy_s;
            SRC_EXT_FAST: tgt_rdy = xrdy_s;
            SRC_LOOP: tgt_rdy = lrdy_s && len_q;
            default: tgt_rdy = 1'b0;
        endcase
        sw_d = sw_q;
        mux_d = mux_q;
        case (sw_q)
            SW_STABLE:
            begin
                if (req_sel != mux_q)
                    sw_d = SW_WAIT;
            end
            SW_WAIT:
            begin
                if (req_sel == mux_q)
                    sw_d = SW_STABLE;
                else if (tgt_rdy)
                begin
                    mux_d = req_sel;
                    sw_d = SW_STABLE;
                end
            end
            default: sw_d = SW_STABLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= CLOCK_CFG_RESET;
            len_q <= 1'b0;
            cfd_q <= 1'b0;
            armed_q <= 1'b0;
            mux_q <= SRC_INT_FAST;
            sw_q <= SW_STABLE;
        end
        else
        begin
            cfg_q <= cfg_d;
            len_q <= len_d;
            cfd_q <= cfd_d;
            armed_q <= armed_d;
            mux_q <= mux_d;
            sw_q <= sw_d;
        end
    end

    // read channel
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb
    begin
        ctl_read = '0;
        ctl_read[CTL_LOOP_EN_BIT] = len_q;
        ctl_read[CTL_LOOP_RDY_BIT] = lrdy_s;
        ctl_read[CTL_FAIL_EN_BIT] = cfd_q;
        ctl_read[CTL_EXT_RDY_BIT] = xrdy_s;
        ctl_read[CTL_INT_RDY_BIT] = irdy_s;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = '0;
            if (s_axi_araddr == CLOCK_CFG_OFFSET)
            begin
                rdata_d = cfg_q;
                rdata_d[STATUS_LSB +: 2] = mux_q;
            end
            else if (s_axi_araddr == LOOP_CTRL_OFFSET)
                rdata_d = ctl_read;
            else
                rresp_d = RESP_SLVERR;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // decoded clock tree controls
    logic [4:0] mul_code;
    logic [5:0] mul_d;
    logic [3:0] out_sel;
    logic [3:0] out_div_d;
    logic out_en_d;
    logic [5:0] mul_q;
    logic out_en_q;
    logic [2:0] out_src_q;
    logic [3:0] out_div_q;

    assign mul_code = {cfg_q[MUL_HI_BIT], cfg_q[MUL_LO_LSB +: 4]};
    assign out_sel = cfg_q[OUT_SEL_LSB +: 4];

    always_comb
    begin
        if (mul_code < MUL_DOUBLE_CODE)
            mul_d = 6'(mul_code) + 6'h02;
        else
            mul_d = 6'(mul_code) + 6'h01;
        out_en_d = out_sel[3] && out_sel <= OUT_SEL_LAST;
        out_div_d = cfg_q[OUT_DIV_LSB +: 4];
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mul_q <= 6'h02;
            out_en_q <= 1'b0;
            out_src_q <= 3'h0;
            out_div_q <= CLOCK_CFG_RESET[OUT_DIV_LSB +: 4];
        end
        else
        begin
            mul_q <= mul_d;
            out_en_q <= out_en_d;
            out_src_q <= out_sel[2:0];
            out_div_q <= out_div_d;
        end
    end

    sccfg_shift_decode #(.W(3)) u_fast (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .code(cfg_q[FAST_DIV_LSB +: 3]),
        .shift_q(fast_periph_bus_shift)
    );
    sccfg_shift_decode #(.W(3)) u_slow (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .code(cfg_q[SLOW_DIV_LSB +: 3]),
        .shift_q(slow_periph_bus_shift)
    );
    sccfg_shift_decode #(.W(4)) u_main (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .code(cfg_q[MAIN_DIV_LSB +: 4]),
        .shift_q(main_bus_shift)
    );

    assign system_clock_mux_sel = mux_q;
    assign loop_enable = len_q;
    assign loop_multiplier = mul_q;
    assign loop_input_halver = cfg_q[HALVER_BIT];
    assign loop_source_select = cfg_q[LOOP_SRC_BIT];
    assign clock_output_enable = out_en_q;
    assign clock_output_select = out_src_q;
    assign output_clock_divider = out_div_q;
    assign fail_detect_armed = armed_q;

    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    chk_mult_locked: assert property (len_q |=> $stable(mul_code))
        else $error("multiplier changed while loop enabled");
    chk_halver_locked: assert property (len_q |=>
        $stable(cfg_q[HALVER_BIT]) && $stable(cfg_q[LOOP_SRC_BIT]))
        else $error("loop input bits changed while loop enabled");
    chk_sel_forced: assert property (lowpower_exit |=>
        req_sel == SRC_INT_FAST)
        else $error("select not forced on low power exit");
    chk_sel_legal: assert property (req_sel != SRC_FORBIDDEN &&
        mux_q != SRC_FORBIDDEN)
        else $error("forbidden source code held");
    chk_loop_held: assert property (mux_q == SRC_LOOP && len_q &&
        !lowpower_enter |=> len_q)
        else $error("loop enable dropped while driving system clock");
    chk_loop_drop: assert property (lowpower_enter |=>
        !len_q ##1 (!len_q || $past(wr_en)))
        else $error("loop enable not cleared on low power entry");
    chk_status_ready: assert property (mux_q != $past(mux_q) |->
        $past(tgt_rdy) && $past(sw_q) == SW_WAIT)
        else $error("status moved before source ready");
    chk_mult_map: assert property ((mul_code == MUL_DOUBLE_CODE) [*2]
        |-> loop_multiplier == 6'h10)
        else $error("multiplier code 01111 not x16");
    chk_fast_shift: assert property (
        (cfg_q[FAST_DIV_LSB +: 3] == 3'h7) [*2] |->
        fast_periph_bus_shift == 3'h4)
        else $error("fast divider 111 not divide by 16");
    chk_main_shift: assert property (
        (cfg_q[MAIN_DIV_LSB +: 4] == 4'hC) [*2] |->
        main_bus_shift == 4'h6)
        else $error("main divider 1100 not divide by 64");
    chk_out_off: assert property (!out_sel[3] |=> !clock_output_enable)
        else $error("clock output enabled with select top bit low");
endmodule

//--- tb/test_sccfg_top.sv
// self-checking bench for the clock configuration register block
module test_sccfg_top
    import sccfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic resetn;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic internal_fast_ready;
    logic external_fast_ready;
    logic loop_ready;
    logic external_fast_fail;
    logic lowpower_enter;
    logic lowpower_exit;
    logic [1:0] system_clock_mux_sel;
    logic loop_enable;
    logic [5:0] loop_multiplier;
    logic loop_input_halver;
    logic loop_source_select;
    logic [3:0] main_bus_shift;
    logic [2:0] fast_periph_bus_shift;
    logic [2:0] slow_periph_bus_shift;
    logic clock_output_enable;
    logic [2:0] clock_output_select;
    logic [3:0] output_clock_divider;
    logic fail_detect_armed;
    int fail_count;
    int checks;
    logic [3:0] strb;

    sccfg_top DUT (
        .ref_clk(ref_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .internal_fast_ready(internal_fast_ready),
        .external_fast_ready(external_fast_ready),
        .loop_ready(loop_ready), .external_fast_fail(external_fast_fail),
        .lowpower_enter(lowpower_enter), .lowpower_exit(lowpower_exit),
        .system_clock_mux_sel(system_clock_mux_sel),
        .loop_enable(loop_enable), .loop_multiplier(loop_multiplier),
        .loop_input_halver(loop_input_halver),
        .loop_source_select(loop_source_select),
        .main_bus_shift(main_bus_shift),
        .fast_periph_bus_shift(fast_periph_bus_shift),
        .slow_periph_bus_shift(slow_periph_bus_shift),
        .clock_output_enable(clock_output_enable),
        .clock_output_select(clock_output_select),
        .output_clock_divider(output_clock_divider),
        .fail_detect_armed(fail_detect_armed)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        logic ah;
        logic wh;
        logic bh;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        bh = 1'b0;
        r = 2'h3;
        while (!bh && n < 100)
        begin
            @(negedge ref_clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            if (bh)
                r = s_axi_bresp;
            @(posedge ref_clk);
            if (ah)
                s_axi_awvalid <= 1'b0;
            if (wh)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        chk(32'(bh), 32'h1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        logic ah;
        logic rh;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        rh = 1'b0;
        d = 32'h0;
        r = 2'h3;
        while (!rh && n < 100)
        begin
            @(negedge ref_clk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            if (rh)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
            end
            @(posedge ref_clk);
            if (ah)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        chk(32'(rh), 32'h1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic wait_mux(input logic [1:0] v);
        int n;
        n = 0;
        while (system_clock_mux_sel !== v && n < 50)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(system_clock_mux_sel), 32'(v));
    endtask

    function automatic logic [5:0] mulx(input logic [4:0] c);
        if (c < 5'h0F)
            return {1'b0, c} + 6'h02;
        else if (c == 5'h0F)
            return 6'h10;
        return {1'b0, c} + 6'h01;
    endfunction

    function automatic logic [3:0] main_sh(input logic [3:0] c);
        if (!c[3])
            return 4'h0;
        else if (!c[2])
            return {2'h0, c[1:0]} + 4'h1;
        return {2'h0, c[1:0]} + 4'h6;
    endfunction

    function automatic logic [2:0] bus_sh(input logic [2:0] c);
        return c[2] ? {1'b0, c[1:0]} + 3'h1 : 3'h0;
    endfunction

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        end_sim;
    end

    initial
    begin
        logic [31:0] d;
        logic [31:0] v;
        logic [1:0] r;
        logic [3:0] c;
        logic [4:0] m;
        logic [4:0] mcodes [5];
        mcodes = '{5'h00, 5'h0E, 5'h0F, 5'h10, 5'h1F};
        fail_count = 0;
        checks = 0;
        strb = 4'hF;
        resetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        internal_fast_ready = 1'b1;
        external_fast_ready = 1'b0;
        loop_ready = 1'b0;
        external_fast_fail = 1'b0;
        lowpower_enter = 1'b0;
        lowpower_exit = 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(negedge ref_clk);
        chk(32'(loop_multiplier), 32'h2);
        chk(32'(output_clock_divider), 32'h2);
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(d, CLOCK_CFG_RESET);
        rd(8'h08, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(8'h08, 32'hFFFF_FFFF, r);
        chk(32'(r), 32'(RESP_SLVERR));
        for (int i = 2; i < 16; i++)
        begin
            c = 4'(i);
            v = {c, 1'b0, c, 5'h00, 4'h0, c[2:0], c[2:0], c, 4'h0};
            wr(CLOCK_CFG_OFFSET, v, r);
            chk(32'(r), 32'(RESP_OKAY));
            settle();
            chk(32'(main_bus_shift), 32'(main_sh(c)));
            chk(32'(fast_periph_bus_shift), 32'(bus_sh(c[2:0])));
            chk(32'(slow_periph_bus_shift), 32'(bus_sh(c[2:0])));
            chk(32'(output_clock_divider), 32'(c));
            chk(32'(clock_output_enable), 32'(c[3] && c <= OUT_SEL_LAST));
            if (c[3] && c <= OUT_SEL_LAST)
                chk(32'(clock_output_select), 32'(c[2:0]));
            rd(CLOCK_CFG_OFFSET, d, r);
            chk(d, v);
        end
        for (int i = 0; i < 5; i++)
        begin
            m = mcodes[i];
            v = {4'h2, m[4], 4'h0, 1'b0, m[3:0], 18'h0};
            wr(CLOCK_CFG_OFFSET, v, r);
            settle();
            chk(32'(loop_multiplier), 32'(mulx(m)));
            rd(CLOCK_CFG_OFFSET, d, r);
            chk(d, v);
        end
        wr(CLOCK_CFG_OFFSET, 32'h2003_0001, r);
        settle();
        chk(32'({loop_input_halver, loop_source_select}), 32'h3);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(32'(system_clock_mux_sel), 32'(SRC_INT_FAST));
        @(posedge ref_clk);
        external_fast_ready <= 1'b1;
        wait_mux(SRC_EXT_FAST);
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(32'(d[3:0]), 32'h5);
        wr(CLOCK_CFG_OFFSET, 32'h2003_000F, r);
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(32'(d[3:0]), 32'h5);
        wr(LOOP_CTRL_OFFSET, 32'h0100_0000, r);
        settle();
        chk(32'(loop_enable), 32'h1);
        rd(LOOP_CTRL_OFFSET, d, r);
        chk(d, 32'h0102_0002);
        @(posedge ref_clk);
        loop_ready <= 1'b1;
        wr(CLOCK_CFG_OFFSET, 32'h283C_0002, r);
        settle();
        chk(32'(loop_multiplier), 32'h2);
        chk(32'({loop_input_halver, loop_source_select}), 32'h3);
        wait_mux(SRC_LOOP);
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(32'(d[3:0]), 32'hA);
        wr(LOOP_CTRL_OFFSET, 32'h0, r);
        settle();
        chk(32'(loop_enable), 32'h1);
        @(posedge ref_clk);
        lowpower_enter <= 1'b1;
        @(posedge ref_clk);
        lowpower_enter <= 1'b0;
        settle();
        chk(32'(loop_enable), 32'h0);
        @(posedge ref_clk);
        lowpower_exit <= 1'b1;
        @(posedge ref_clk);
        lowpower_exit <= 1'b0;
        settle();
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(32'(d[1:0]), 32'(SRC_INT_FAST));
        wait_mux(SRC_INT_FAST);
        chk(32'(fail_detect_armed), 32'h0);
        wr(LOOP_CTRL_OFFSET, 32'h0008_0000, r);
        settle();
        settle();
        chk(32'(fail_detect_armed), 32'h1);
        wr(CLOCK_CFG_OFFSET, 32'h2000_0001, r);
        wait_mux(SRC_EXT_FAST);
        @(posedge ref_clk);
        external_fast_fail <= 1'b1;
        repeat (4) @(posedge ref_clk);
        external_fast_fail <= 1'b0;
        settle();
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(32'(d[1:0]), 32'(SRC_INT_FAST));
        wait_mux(SRC_INT_FAST);
        strb = 4'h2;
        wr(CLOCK_CFG_OFFSET, 32'hFFFF_A5FF, r);
        settle();
        chk(32'(fast_periph_bus_shift), 32'h1);
        chk(32'(slow_periph_bus_shift), 32'h2);
        rd(CLOCK_CFG_OFFSET, d, r);
        chk(d, 32'h2000_2500);
        end_sim;
    end
endmodule
